// file: src/ipv_arbiter.v
/*
  Fixed priority pick among six pending sources, index 0 highest.
  Assumes request bits are already qualified by their enables.
*/
`timescale 1ns/1ps
`include "ipv_regs.vh"

module ipv_arbiter (
    input  wire [5:0] req_in,
    output reg  [5:0] grant_out,
    output reg  [7:0] vector_out,
    output wire       any_out
);
    assign any_out = |req_in;

    always @* begin
        grant_out  = 6'h00;
        vector_out = 8'h00;
        if (req_in[0]) begin                       // [RL4]
            grant_out  = 6'h01;
            vector_out = `IPV_VEC_EXT;              // [RL5]
        end else if (req_in[1]) begin
            grant_out  = 6'h02;
            vector_out = `IPV_VEC_T0;
        end else if (req_in[2]) begin
            grant_out  = 6'h04;
            vector_out = `IPV_VEC_T1;
        end else if (req_in[3]) begin
            grant_out  = 6'h08;
            vector_out = `IPV_VEC_T2;
        end else if (req_in[4]) begin
            grant_out  = 6'h10;
            vector_out = `IPV_VEC_ADC;
        end else if (req_in[5]) begin
            grant_out  = 6'h20;
            vector_out = `IPV_VEC_TOUCH;           // [RL8]
        end
    end
endmodule

// file: src/ipv_interrupt_ctrl.v
/*
  Interrupt controller: two control registers with enables and request flags,
  fixed priority vectoring to the core sequencer, power-down wake-up and an
  AXI4-Lite register slave with a sticky status/mask pair for host interrupts.
  Assumes all event inputs are one-cycle pulses synchronous to clock_in.
*/
// Decided for this implementation: the AXI4-Lite register port and the register offsets.
// Behaviour
// RL1: Control-high bits 0..2 enable the timer 2, converter and touch interrupts.
// RL2: Control-high bits 4..6 are the timer 2, converter and touch request flags.
// RL3: Control-high bits 3 and 7 always read as zero.
// RL4: Pending enabled requests are served external, timer 0, timer 1, timer 2, converter, touch.
// RL5: Vectors are 04h, 08h, 0ch, 10h, 14h and 18h in that priority order.
// RL6: A request flag stays set until serviced or cleared by software.
// RL7: The touch flag is set by the touch sensor completion signal.
// RL8: An enabled, set touch flag with room on the stack calls address 18h.
// RL9: Taking a vector clears its flag and the global enable; the code clears the flag granted at acceptance, even if the vector differs.
// RL10: Power-down ends on any interrupt, port A transition, watchdog or timer overflow.
// RL11: Control-low bit 0 is the global enable; nothing is vectored while it is zero. The code gates only raising the call; a held call is still taken.
// RL12: Return-from-interrupt sets the global enable, a plain return does not.
// RL13: No request is acknowledged while the return stack is full. The code only blocks raising the call; a call already held is still accepted.
// RL14: Software writes to enables and flags store the written value.
// RL15: A hardware flag set wins over a simultaneous software write of zero.
`timescale 1ns/1ps
`include "ipv_regs.vh"

module ipv_interrupt_ctrl (
    input  wire        clock_in,
    input  wire        sys_rst_in,
    // AXI4-Lite slave
    input  wire [4:0]  s_axi_awaddr_in,
    input  wire        s_axi_awvalid_in,
    output reg         s_axi_awready_out,
    input  wire [31:0] s_axi_wdata_in,
    input  wire [3:0]  s_axi_wstrb_in,
    input  wire        s_axi_wvalid_in,
    output reg         s_axi_wready_out,
    output reg  [1:0]  s_axi_bresp_out,
    output reg         s_axi_bvalid_out,
    input  wire        s_axi_bready_in,
    input  wire [4:0]  s_axi_araddr_in,
    input  wire        s_axi_arvalid_in,
    output reg         s_axi_arready_out,
    output reg  [31:0] s_axi_rdata_out,
    output reg  [1:0]  s_axi_rresp_out,
    output reg         s_axi_rvalid_out,
    input  wire        s_axi_rready_in,
    // Peripheral event pulses
    input  wire        ext_event_in,
    input  wire        timer0_ovf_in,
    input  wire        timer1_ovf_in,
    input  wire        timer2_ovf_in,
    input  wire        adc_done_in,
    input  wire        touch_done_in,
    input  wire        porta_wake_in,
    input  wire        wdt_ovf_in,
    // Core sequencer and host interrupt
    input  wire        stack_full_in,
    input  wire        call_ready_in,
    input  wire        return_from_interrupt_instr_exec_in,
    input  wire        power_down_in,
    output reg         call_req_out,
    output reg  [7:0]  call_vector_out,
    output reg         wake_out,
    output reg         irq_out
);
    reg  [7:0] ctrl_low_ff;
    reg  [7:0] ctrl_high_ff;
    reg  [2:0] irq_status_ff;
    reg  [2:0] irq_mask_ff;
    reg        aw_held_ff;
    reg        w_held_ff;
    reg  [4:0] aw_addr_ff;
    reg  [31:0] w_data_ff;
    reg  [3:0] w_strb_ff;
    reg  [7:0] nxt_ctrl_low;
    reg  [7:0] nxt_ctrl_high;
    reg  [2:0] nxt_status;
    reg  [31:0] rd_word;
    reg        rd_hit;

    wire [5:0] flags;
    wire [5:0] enables;
    wire [5:0] grant;
    wire [7:0] vector;
    wire       any_req;
    wire       wr_fire;
    wire       take;
    wire       stack_block;

    assign flags   = {ctrl_high_ff[`IPV_BIT_TOUCH_FLAG], ctrl_high_ff[`IPV_BIT_ADC_FLAG],
                      ctrl_high_ff[`IPV_BIT_T2_FLAG],    ctrl_low_ff[`IPV_BIT_T1_FLAG],
                      ctrl_low_ff[`IPV_BIT_T0_FLAG],     ctrl_low_ff[`IPV_BIT_EXT_FLAG]};
    assign enables = {ctrl_high_ff[`IPV_BIT_TOUCH_EN],   ctrl_high_ff[`IPV_BIT_ADC_EN],    // [RL1]
                      ctrl_high_ff[`IPV_BIT_T2_EN],      ctrl_low_ff[`IPV_BIT_T1_EN],
                      ctrl_low_ff[`IPV_BIT_T0_EN],       ctrl_low_ff[`IPV_BIT_EXT_EN]};

    ipv_arbiter u_arb (
        .req_in     (flags & enables),
        .grant_out  (grant),
        .vector_out (vector),
        .any_out    (any_req)
    );

    // A call is raised only with the global enable set and the stack not full
    assign stack_block = stack_full_in & any_req & ctrl_low_ff[`IPV_BIT_GLOBAL_EN];
    assign take = call_req_out & call_ready_in;
    assign wr_fire = aw_held_ff & w_held_ff & ~s_axi_bvalid_out;

    function [7:0] merge_byte;
        input [7:0] old_val;
        input [31:0] data;
        input [3:0] strb;
        begin
            merge_byte = strb[0] ? data[7:0] : old_val;
        end
    endfunction

    // Control registers: software write first, then hardware effects on top
    always @* begin
        nxt_ctrl_low  = ctrl_low_ff;
        nxt_ctrl_high = ctrl_high_ff;
        if (wr_fire && aw_addr_ff[4:2] == `IPV_OFS_CTRL_LOW >> 2)
            nxt_ctrl_low = merge_byte(ctrl_low_ff, w_data_ff, w_strb_ff)    // [RL14]
                           & `IPV_CTRL_LOW_MASK;
        if (wr_fire && aw_addr_ff[4:2] == `IPV_OFS_CTRL_HIGH >> 2)
            nxt_ctrl_high = merge_byte(ctrl_high_ff, w_data_ff, w_strb_ff)  // [RL14]
                            & `IPV_CTRL_HIGH_MASK;                           // [RL3]
        if (take) begin
            nxt_ctrl_low[`IPV_BIT_GLOBAL_EN] = 1'b0;                         // [RL9]
            if (grant[0]) nxt_ctrl_low[`IPV_BIT_EXT_FLAG]   = 1'b0;
            if (grant[1]) nxt_ctrl_low[`IPV_BIT_T0_FLAG]    = 1'b0;
            if (grant[2]) nxt_ctrl_low[`IPV_BIT_T1_FLAG]    = 1'b0;
            if (grant[3]) nxt_ctrl_high[`IPV_BIT_T2_FLAG]   = 1'b0;
            if (grant[4]) nxt_ctrl_high[`IPV_BIT_ADC_FLAG]  = 1'b0;
            if (grant[5]) nxt_ctrl_high[`IPV_BIT_TOUCH_FLAG] = 1'b0;         // [RL9]
        end
        if (return_from_interrupt_instr_exec_in)
            nxt_ctrl_low[`IPV_BIT_GLOBAL_EN] = 1'b1;                         // [RL12]
        // New events win over clears so none is lost
        if (ext_event_in)  nxt_ctrl_low[`IPV_BIT_EXT_FLAG]   = 1'b1;        // [RL15]
        if (timer0_ovf_in) nxt_ctrl_low[`IPV_BIT_T0_FLAG]    = 1'b1;
        if (timer1_ovf_in) nxt_ctrl_low[`IPV_BIT_T1_FLAG]    = 1'b1;
        if (timer2_ovf_in) nxt_ctrl_high[`IPV_BIT_T2_FLAG]   = 1'b1;        // [RL2]
        if (adc_done_in)   nxt_ctrl_high[`IPV_BIT_ADC_FLAG]  = 1'b1;        // [RL2]
        if (touch_done_in) nxt_ctrl_high[`IPV_BIT_TOUCH_FLAG] = 1'b1;       // [RL7]
    end

    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            ctrl_low_ff  <= `IPV_CTRL_LOW_RST;
            ctrl_high_ff <= `IPV_CTRL_HIGH_RST;
        end else begin
            // Flags hold their value otherwise [RL6]
            ctrl_low_ff  <= nxt_ctrl_low;
            ctrl_high_ff <= nxt_ctrl_high;
        end
    end

    // Vectored call to the core sequencer; held until the core accepts it
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            call_req_out    <= 1'b0;
            call_vector_out <= 8'h00;
            wake_out        <= 1'b0;
        end else begin
            if (take) begin
                call_req_out <= 1'b0;
            end else if (!call_req_out) begin
                // Global enable gate and stack full gate [RL11] [RL13]
                call_req_out    <= any_req & ctrl_low_ff[`IPV_BIT_GLOBAL_EN]
                                   & ~stack_full_in & ~take;
                call_vector_out <= vector;                                   // [RL4] [RL5] [RL8]
            end
            // Any pending request wakes, even if masked by the global enable
            wake_out <= power_down_in & ((|flags) | ext_event_in | timer0_ovf_in   // [RL10]
                        | timer1_ovf_in | timer2_ovf_in | adc_done_in | touch_done_in
                        | porta_wake_in | wdt_ovf_in);
        end
    end

    // Host interrupt status: set wins over write-one-to-clear
    always @* begin
        nxt_status = irq_status_ff;
        if (wr_fire && aw_addr_ff[4:2] == `IPV_OFS_IRQ_STATUS >> 2 && w_strb_ff[0])
            nxt_status = nxt_status & ~w_data_ff[2:0];
        if (take)        nxt_status[`IPV_ST_VECTORED]    = 1'b1;
        if (stack_block) nxt_status[`IPV_ST_STACK_BLOCK] = 1'b1;
        if (wake_out)    nxt_status[`IPV_ST_WAKE]        = 1'b1;
    end

    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            irq_status_ff <= 3'h0;
            irq_mask_ff   <= 3'h0;
            irq_out       <= 1'b0;
        end else begin
            irq_status_ff <= nxt_status;
            if (wr_fire && aw_addr_ff[4:2] == `IPV_OFS_IRQ_MASK >> 2 && w_strb_ff[0])
                irq_mask_ff <= w_data_ff[2:0];
            irq_out <= |(nxt_status & irq_mask_ff);
        end
    end

    // AXI4-Lite write path: address and data taken in either order
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            aw_held_ff        <= 1'b0;
            w_held_ff         <= 1'b0;
            aw_addr_ff        <= 5'h00;
            w_data_ff         <= 32'h0000_0000;
            w_strb_ff         <= 4'h0;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b0;
            s_axi_bresp_out   <= 2'b00;
        end else begin
            s_axi_awready_out <= ~aw_held_ff & ~s_axi_awready_out & ~s_axi_bvalid_out;
            s_axi_wready_out  <= ~w_held_ff & ~s_axi_wready_out & ~s_axi_bvalid_out;
            if (s_axi_awvalid_in && s_axi_awready_out) begin
                aw_held_ff        <= 1'b1;
                aw_addr_ff        <= s_axi_awaddr_in;
                s_axi_awready_out <= 1'b0;
            end
            if (s_axi_wvalid_in && s_axi_wready_out) begin
                w_held_ff        <= 1'b1;
                w_data_ff        <= s_axi_wdata_in;
                w_strb_ff        <= s_axi_wstrb_in;
                s_axi_wready_out <= 1'b0;
            end
            if (wr_fire) begin
                aw_held_ff       <= 1'b0;
                w_held_ff        <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out  <= (aw_addr_ff > `IPV_OFS_VECTOR) ? 2'b10 : 2'b00;
            end else if (s_axi_bvalid_out && s_axi_bready_in) begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Read decode; unused bit positions come back as zero
    always @* begin
        rd_word = 32'h0000_0000;
        rd_hit  = 1'b1;
        case (s_axi_araddr_in[4:2])
            3'h0:    rd_word[7:0] = ctrl_low_ff;
            3'h1:    rd_word[7:0] = ctrl_high_ff & `IPV_CTRL_HIGH_MASK;     // [RL3]
            3'h2:    rd_word[2:0] = irq_status_ff;
            3'h3:    rd_word[2:0] = irq_mask_ff;
            3'h4:    rd_word = {23'h000000, call_req_out, call_vector_out};
            default: rd_hit = 1'b0;
        endcase
    end

    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b0;
            s_axi_rdata_out   <= 32'h0000_0000;
            s_axi_rresp_out   <= 2'b00;
        end else begin
            s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out;
            if (s_axi_arvalid_in && s_axi_arready_out) begin
                s_axi_arready_out <= 1'b0;
                s_axi_rvalid_out  <= 1'b1;
                s_axi_rdata_out   <= rd_word;
                s_axi_rresp_out   <= rd_hit ? 2'b00 : 2'b10;
            end else if (s_axi_rvalid_out && s_axi_rready_in) begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end
endmodule

// file: src/ipv_regs.vh
/*
  Register map and field positions of the interrupt priority and vectoring block.
  Assumes byte addressing on a 32-bit AXI4-Lite bus, one register per aligned word.
*/
`ifndef IPV_REGS_VH
`define IPV_REGS_VH

`define IPV_OFS_CTRL_LOW     5'h00
`define IPV_OFS_CTRL_HIGH    5'h04
`define IPV_OFS_IRQ_STATUS   5'h08
`define IPV_OFS_IRQ_MASK     5'h0c
`define IPV_OFS_VECTOR       5'h10

`define IPV_BIT_GLOBAL_EN    0
`define IPV_BIT_EXT_EN       1
`define IPV_BIT_T0_EN        2
`define IPV_BIT_T1_EN        3
`define IPV_BIT_EXT_FLAG     4
`define IPV_BIT_T0_FLAG      5
`define IPV_BIT_T1_FLAG      6

`define IPV_BIT_T2_EN        0
`define IPV_BIT_ADC_EN       1
`define IPV_BIT_TOUCH_EN     2
`define IPV_BIT_T2_FLAG      4
`define IPV_BIT_ADC_FLAG     5
`define IPV_BIT_TOUCH_FLAG   6

`define IPV_CTRL_LOW_RST     8'h00
`define IPV_CTRL_HIGH_RST    8'h00
`define IPV_CTRL_HIGH_MASK   8'h77
`define IPV_CTRL_LOW_MASK    8'h7f

`define IPV_VEC_EXT          8'h04
`define IPV_VEC_T0           8'h08
`define IPV_VEC_T1           8'h0c
`define IPV_VEC_T2           8'h10
`define IPV_VEC_ADC          8'h14
`define IPV_VEC_TOUCH        8'h18

`define IPV_ST_VECTORED      0
`define IPV_ST_STACK_BLOCK   1
`define IPV_ST_WAKE          2

`endif

// file: testbench/ipv_checker.sv
/* Checker for the core call link and wake output of the interrupt vectoring block.
   Assumes one clock domain and a synchronous active high reset. */
`timescale 1ns/1ps
module ipv_checker (
    input wire       clock_in,
    input wire       sys_rst_in,
    input wire       call_req_out,
    input wire [7:0] call_vector_out,
    input wire       call_ready_in,
    input wire       stack_full_in,
    input wire       return_from_interrupt_instr_exec_in,
    input wire       power_down_in,
    input wire       porta_wake_in,
    input wire       wdt_ovf_in,
    input wire       timer2_ovf_in,
    input wire       wake_out,
    input wire       s_axi_awvalid_in,
    input wire       s_axi_wvalid_in,
    input wire       s_axi_bvalid_out
);
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (sys_rst_in);
    wire quiet = !s_axi_awvalid_in && !s_axi_wvalid_in && !s_axi_bvalid_out && !return_from_interrupt_instr_exec_in;
    property p_vec_legal;
        call_req_out |-> call_vector_out inside {8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18};
    endproperty
    a_vec_legal: assert property (p_vec_legal)
        else $error("call vector outside the vector table");
    property p_stack_rise;
        $rose(call_req_out) |-> !$past(stack_full_in);
    endproperty
    a_stack_rise: assert property (p_stack_rise)
        else $error("call raised while stack full");
    property p_stack_hold;
        stack_full_in && !call_req_out |=> !call_req_out;
    endproperty
    a_stack_hold: assert property (p_stack_hold)
        else $error("call raised after stack full cycle");
    property p_req_hold;
        call_req_out && !call_ready_in |=> call_req_out && $stable(call_vector_out);
    endproperty
    a_req_hold: assert property (p_req_hold)
        else $error("call request dropped or vector changed before acceptance");
    property p_take_drop;
        call_req_out && call_ready_in |=> !call_req_out;
    endproperty
    a_take_drop: assert property (p_take_drop)
        else $error("call request still high after acceptance");
    property p_ge_clear;
        call_req_out && call_ready_in && quiet ##1 quiet |=> !call_req_out;
    endproperty
    a_ge_clear: assert property (p_ge_clear)
        else $error("new call while global enable should be clear");
    property p_wake;
        power_down_in && (porta_wake_in || wdt_ovf_in) |=> wake_out;
    endproperty
    a_wake: assert property (p_wake)
        else $error("no wake after port or watchdog cause");
    property p_wake_ev;
        power_down_in && timer2_ovf_in ##1 power_down_in |=> wake_out;
    endproperty
    a_wake_ev: assert property (p_wake_ev)
        else $error("no wake after timer event");
endmodule

bind ipv_interrupt_ctrl ipv_checker u_chk (
    .clock_in(clock_in), .sys_rst_in(sys_rst_in), .call_req_out(call_req_out),
    .call_vector_out(call_vector_out), .call_ready_in(call_ready_in),
    .stack_full_in(stack_full_in), .return_from_interrupt_instr_exec_in(return_from_interrupt_instr_exec_in),
    .power_down_in(power_down_in), .porta_wake_in(porta_wake_in), .wdt_ovf_in(wdt_ovf_in),
    .timer2_ovf_in(timer2_ovf_in), .wake_out(wake_out), .s_axi_awvalid_in(s_axi_awvalid_in),
    .s_axi_wvalid_in(s_axi_wvalid_in), .s_axi_bvalid_out(s_axi_bvalid_out));

// file: testbench/ipv_core_model.sv
/* Behavioural core sequencer: accepts vectored calls promptly or after a stall,
   records the vector and optionally returns with return-from-interrupt. */
`timescale 1ns/1ps
module ipv_core_model (
    input  wire        clock_in,
    input  wire        sys_rst_in,
    input  wire        call_req_in,
    input  wire  [7:0] call_vector_in,
    input  wire        slow_in,
    input  wire        return_from_interrupt_instr_en_in,
    output logic       call_ready_out,
    output logic       return_from_interrupt_instr_exec_out,
    output logic [7:0] taken_vec_out,
    output logic [7:0] taken_cnt_out
);
    logic [3:0] lat_ff;
    logic [3:0] svc_ff;
    always @(posedge clock_in) begin
        if (sys_rst_in) begin
            call_ready_out <= 1'b0;
            return_from_interrupt_instr_exec_out <= 1'b0;
            taken_vec_out <= 8'h00;
            taken_cnt_out <= 8'h00;
            lat_ff <= 4'h0;
            svc_ff <= 4'h0;
        end else begin
            return_from_interrupt_instr_exec_out <= return_from_interrupt_instr_en_in && svc_ff == 4'h1;
            svc_ff <= (svc_ff != 4'h0) ? svc_ff - 4'h1 : 4'h0;
            if (call_req_in && call_ready_out) begin
                call_ready_out <= 1'b0;
                taken_vec_out <= call_vector_in;
                taken_cnt_out <= taken_cnt_out + 8'h01;
                lat_ff <= 4'h0;
                svc_ff <= 4'h5;
            end else begin
                // Stalls make the block hold its request and vector
                lat_ff <= call_req_in ? lat_ff + 4'h1 : 4'h0;
                call_ready_out <= call_req_in && (!slow_in || lat_ff >= 4'h2);
            end
        end
    end
endmodule

// file: testbench/tb.sv
/* Self-checking bench: registers over AXI4-Lite, vectored calls through a core model,
   stack blocking, host interrupt and wake. Assumes the register map of the header. */
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin err_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module tb;
    localparam [4:0] A_LO = 5'h00, A_HI = 5'h04, A_ST = 5'h08, A_MK = 5'h0c, A_BAD = 5'h14;
    logic        clk = 1'b0, rst = 1'b1, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, porta = 1'b0, wdt = 1'b0, stack_full = 1'b0;
    logic        pdn = 1'b0, slow = 1'b0, return_from_interrupt_instr_en = 1'b0;
    logic [4:0]  awaddr = 5'h00, araddr = 5'h00;
    logic [31:0] wdata = 32'h0, rdat;
    logic [5:0]  ev = 6'h00;
    logic [1:0]  rrsp, brsp;
    logic [7:0]  d, cnt;
    wire         awready, wready, bvalid, arready, rvalid, call_req, call_ready, return_from_interrupt_instr, wake, irq;
    wire [1:0]   bresp, rresp;
    wire [31:0]  rdata;
    wire [7:0]   vec, taken_vec, taken_cnt;
    int          err_count = 0, samples_checked = 0, seed = 81161, i;
    always #4 clk = ~clk;
    ipv_interrupt_ctrl dut (.clock_in(clk), .sys_rst_in(rst), .s_axi_awaddr_in(awaddr),
        .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready), .s_axi_wdata_in(wdata),
        .s_axi_wstrb_in(4'hf), .s_axi_wvalid_in(wvalid), .s_axi_wready_out(wready),
        .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid), .s_axi_bready_in(bready),
        .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid), .s_axi_arready_out(arready),
        .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rvalid),
        .s_axi_rready_in(rready), .ext_event_in(ev[0]), .timer0_ovf_in(ev[1]),
        .timer1_ovf_in(ev[2]), .timer2_ovf_in(ev[3]), .adc_done_in(ev[4]),
        .touch_done_in(ev[5]), .porta_wake_in(porta), .wdt_ovf_in(wdt),
        .stack_full_in(stack_full), .call_ready_in(call_ready), .return_from_interrupt_instr_exec_in(return_from_interrupt_instr),
        .power_down_in(pdn), .call_req_out(call_req), .call_vector_out(vec),
        .wake_out(wake), .irq_out(irq));
    ipv_core_model u_core (.clock_in(clk), .sys_rst_in(rst), .call_req_in(call_req),
        .call_vector_in(vec), .slow_in(slow), .return_from_interrupt_instr_en_in(return_from_interrupt_instr_en),
        .call_ready_out(call_ready), .return_from_interrupt_instr_exec_out(return_from_interrupt_instr), .taken_vec_out(taken_vec),
        .taken_cnt_out(taken_cnt));
    function automatic [7:0] vec_of(input int k);
        return 8'h04 + 8'(k * 4);
    endfunction
    task automatic wr(input [4:0] a, input [7:0] v);
        awaddr <= a;
        wdata <= {24'h0, v};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
            if (bvalid && bready) begin
                brsp = bresp;
                bready <= 1'b0;
            end
        end while (awvalid || wvalid || bready);
        // Let one edge pass so the next call does not reassign bready in this step
        @(posedge clk);
    endtask
    task automatic rd(input [4:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
            if (rvalid && rready) begin
                rdat = rdata;
                rrsp = rresp;
                rready <= 1'b0;
            end
        end while (arvalid || rready);
        @(posedge clk);
    endtask
    task automatic pulse(input [5:0] m);
        ev <= m;
        @(posedge clk);
        ev <= 6'h00;
        @(posedge clk);
    endtask
    task automatic wait_take(input [7:0] old);
        int n;
        n = 0;
        while (taken_cnt === old && n < 200) begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic report_and_stop;
        $display("Checks %0d, mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial begin
        repeat (20000) @(posedge clk);
        err_count++;
        report_and_stop;
    end
    initial begin
        repeat (4) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        rd(A_LO);
        `CHK(rdat[7:0], 8'h00)
        for (i = 0; i < 8; i++) begin
            d = (i == 0) ? 8'h88 : 8'($random(seed));
            wr(A_HI, d);
            rd(A_HI);
            `CHK(rdat[7:0], d & 8'h77)
        end
        rd(A_BAD);
        `CHK(rrsp, 2'b10)
        wr(A_BAD, 8'h01);
        `CHK(brsp, 2'b10)
        wr(A_MK, 8'h00);
        `CHK(brsp, 2'b00)
        wr(A_HI, 8'h04);
        pulse(6'h20);
        repeat (8) @(posedge clk);
        rd(A_HI);
        `CHK(rdat[7:0], 8'h44)
        cnt = taken_cnt;
        wr(A_LO, 8'h01);
        wait_take(cnt);
        `CHK(taken_vec, 8'h18)
        rd(A_HI);
        `CHK(rdat[7:0], 8'h04)
        rd(A_LO);
        `CHK(rdat[7:0], 8'h00)
        rd(A_ST);
        `CHK(rdat[0], 1'b1)
        `CHK(irq, 1'b0)
        wr(A_MK, 8'h01);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b1)
        wr(A_ST, 8'h01);
        repeat (3) @(posedge clk);
        `CHK(irq, 1'b0)
        stack_full <= 1'b1;
        cnt = taken_cnt;
        wr(A_HI, 8'h11);
        wr(A_LO, 8'h01);
        repeat (20) @(posedge clk);
        `CHK(taken_cnt, cnt)
        stack_full <= 1'b0;
        wait_take(cnt);
        `CHK(taken_vec, 8'h10)
        return_from_interrupt_instr_en <= 1'b1;
        slow <= 1'b1;
        wr(A_HI, 8'h07);
        wr(A_LO, 8'h0e);
        pulse(6'h3f);
        cnt = taken_cnt;
        wr(A_LO, 8'h7f);
        for (i = 0; i < 6; i++) begin
            wait_take(cnt);
            `CHK(taken_vec, vec_of(i))
            cnt = taken_cnt;
        end
        return_from_interrupt_instr_en <= 1'b0;
        for (i = 0; i < 2; i++) begin
            pdn <= 1'b1;
            {wdt, porta} <= 2'(i + 1);
            @(posedge clk);
            {wdt, porta} <= 2'b00;
            @(posedge clk);
            `CHK(wake, 1'b1)
            pdn <= 1'b0;
            repeat (3) @(posedge clk);
        end
        pdn <= 1'b1;
        pulse(6'h08);
        repeat (2) @(posedge clk);
        pdn <= 1'b0;
        report_and_stop;
    end
endmodule
